/* File: sasr_pkg.sv */
package sasr_pkg;
	localparam int RES_W = 12;
	localparam int CLK_NS = 4;
	localparam int T_CONVERT_STROBE_N_NS = 14000;
	localparam int T_RISE0_NS = 1400;
	localparam int T_PER_NS = 1100;
	localparam int T_HIGH_NS = 350;
	localparam int T_TAIL_NS = 800;
	localparam int T_BUSY_MAX_NS = 20000;
	localparam int T_CYCLE_MAX_NS = 25000;
	localparam int T_ACQ_MAX_NS = 5000;
	localparam logic [12:0] RISE0_C = 13'(T_RISE0_NS / CLK_NS);
	localparam logic [8:0] PER_C = 9'(T_PER_NS / CLK_NS);
	localparam logic [8:0] HIGH_C = 9'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [12:0] TAIL_C = 13'(T_TAIL_NS / CLK_NS);
	localparam logic [8:0] DEC_C = 9'(T_CONVERT_STROBE_N_NS / (CLK_NS * RES_W));
	localparam logic [12:0] BUSY_C = RISE0_C + 13'(RES_W - 1) * 13'(PER_C) + 13'(HIGH_C) + TAIL_C;
	localparam logic [12:0] BUSY_MAX_C = 13'(T_BUSY_MAX_NS / CLK_NS);
	localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
	localparam logic [3:0] SAR_MSB_IDX = 4'hb;
	localparam logic [3:0] SAR_DONE_IDX = 4'hf;
	localparam logic [3:0] BIT_COUNT = 4'hc;
	localparam logic RST_BUSY_N = 1'b1;
	localparam int SYNC_W = 5;
	localparam int FIFO_DEPTH = 4;
	typedef enum logic [2:0] {
		SASR_IDLE = 3'b001,
		SASR_CONVERT_STROBE_N = 3'b010,
		SASR_COPY = 3'b100
	} sasr_mode_type;
endpackage : sasr_pkg

/* File: sasr_top.sv */
// Summary of operation
// R1: Internal mode: convert edge starts conversion and readout.
// R2: Busy low from start until conversion completes.
// R3: Internal mode: prior result shifts out during conversion.
// R4: Twelve bits, two's complement, MSB first.
// R5: Internal data stable on both clock edges.
// R6: Internal mode: busy stays low across whole serial transfer.
// R7: Result copied to shifter just before busy rises.
// R8: External mode: shifter advances only on host clock.
// R9: Host should clock externally after conversion finishes.
// R10: Convert edges ignored while conversion active.
// R11: Conversion start ignores device select.
// R12: Host starts conversions at most every 25 us.
// R13: Host keeps convert static after 8 us.
// R14: Host keeps convert high 2 us before start.
// R15: Host holds convert low at least 40 ns.
// R16: Host may use short 100 ns convert pulse.
// R17: Conversion plus acquisition within 25 us.
// R18: First internal clock rise 1.4 us, period 1.1 us.
// R19: Busy rises 800 ns after last clock fall.
// R20: Host waits 120 ns before external clocking.
// R21: Host keeps clock low 2 us before busy.
// R22: Codes 7FF down to 800, midscale 000.
// R23: Select high takes host clock, low drives clock.
// R24: Outputs enabled only while device select low.
// R25: Clock high at copy keeps old contents.
// R26: Thirteenth external rise onward drives data low.
// R27: Twelve timed successive-approximation decisions form result.
`timescale 1ns/1ps
module sasr_fifo #(
	parameter int W = 12,
	parameter int D = 4
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} sasr_fifo_type;
	sasr_fifo_type q_ff;
	sasr_fifo_type nxt_q;
	logic push;
	logic pop;

	assign in_ready_o = (q_ff.cnt != (AW + 1)'(D));
	assign out_valid_o = (q_ff.cnt != '0);
	assign out_data_o = q_ff.mem[q_ff.rp];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_comb begin
		nxt_q = q_ff;
		if (push) begin
			nxt_q.mem[q_ff.wp] = in_data_i;
			nxt_q.wp = (q_ff.wp == AW'(D - 1)) ? '0 : q_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_q.rp = (q_ff.rp == AW'(D - 1)) ? '0 : q_ff.rp + 1'b1;
		end
		nxt_q.cnt = q_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end
endmodule : sasr_fifo

module sasr_top (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire logic CONVERT_STROBE_N_I,
	input wire logic DEVICE_SELECT_N_I,
	input wire logic CLOCK_SOURCE_SELECT_I,
	input wire logic SERIAL_BIT_CLOCK_I,
	input wire logic COMPARE_I,
	output logic SERIAL_BIT_CLOCK_O,
	output logic SERIAL_BIT_CLOCK_OE_O,
	output logic DATA_O,
	output logic DATA_OE_O,
	output logic BUSY_N_O,
	output logic BUSY_OE_O,
	output logic SAMPLE_HOLD_O,
	output logic [11:0] TRIAL_CODE_O
);
	localparam int TAIL_LO = 200;
	localparam int TAIL_HI = 202;
	typedef struct packed {
		logic [sasr_pkg::SYNC_W-1:0] s1;
		logic [sasr_pkg::SYNC_W-1:0] s2;
		logic [sasr_pkg::SYNC_W-1:0] s3;
		sasr_pkg::sasr_mode_type st;
		logic [12:0] cyc;
		logic [11:0] trial;
		logic [3:0] bitp;
		logic [8:0] dec;
		logic push;
		logic [11:0] sr;
		logic [8:0] ph;
		logic [3:0] nbit;
		logic iclk;
		logic dout;
		logic busy_n;
		logic hold;
		logic data_oe;
		logic clk_oe;
		logic busy_oe;
	} sasr_state_type;
	sasr_state_type q_ff;
	sasr_state_type nxt_q;
	logic convert_strobe_n_fall;
	logic cs_n;
	logic ext;
	logic ext_rise;
	logic load_ok;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [11:0] fifo_out_data;
	logic [11:0] result;

	assign convert_strobe_n_fall = q_ff.s3[0] & ~q_ff.s2[0];
	assign cs_n = q_ff.s2[1];
	assign ext = q_ff.s2[2];
	// R8: host clock gated
	assign ext_rise = ext & ~cs_n & q_ff.s2[3] & ~q_ff.s3[3];
	// R25: load condition
	assign load_ok = ~ext | ~q_ff.s2[3] | cs_n;
	// R22: flip MSB
	assign result = {~q_ff.trial[11], q_ff.trial[10:0]};
	assign fifo_out_ready = (q_ff.st == sasr_pkg::SASR_COPY);

	sasr_fifo #(
		.W(sasr_pkg::RES_W),
		.D(sasr_pkg::FIFO_DEPTH)
	) u_fifo (
		.SYS_CLK_I(SYS_CLK_I),
		.RST_B_I(RST_B_I),
		.in_valid_i(q_ff.push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(result),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	always_comb begin
		nxt_q = q_ff;
		nxt_q.s1 = {COMPARE_I, SERIAL_BIT_CLOCK_I, CLOCK_SOURCE_SELECT_I, DEVICE_SELECT_N_I, CONVERT_STROBE_N_I};
		nxt_q.s2 = q_ff.s1;
		nxt_q.s3 = q_ff.s2;
		if (q_ff.push && fifo_in_ready) begin
			nxt_q.push = 1'b0;
		end
		// R26: zero fill after twelve
		if (ext_rise) begin
			nxt_q.dout = q_ff.sr[11];
			nxt_q.sr = {q_ff.sr[10:0], 1'b0};
		end
		case (q_ff.st)
			sasr_pkg::SASR_IDLE: begin
				// R1: start and readout
				// R10: start only when idle
				// R11: select not consulted
				if (convert_strobe_n_fall) begin
					nxt_q.st = sasr_pkg::SASR_CONVERT_STROBE_N;
					nxt_q.cyc = '0;
					// R2: busy falls
					nxt_q.busy_n = 1'b0;
					nxt_q.hold = 1'b1;
					nxt_q.trial = sasr_pkg::SAR_FIRST_TRIAL;
					nxt_q.bitp = sasr_pkg::SAR_MSB_IDX;
					nxt_q.dec = '0;
					nxt_q.ph = '0;
					nxt_q.nbit = '0;
				end
			end
			sasr_pkg::SASR_CONVERT_STROBE_N: begin
				nxt_q.cyc = q_ff.cyc + 13'h1;
				// R27: timed SAR decisions
				if (q_ff.bitp != sasr_pkg::SAR_DONE_IDX) begin
					if (q_ff.dec == sasr_pkg::DEC_C - 9'h1) begin
						nxt_q.dec = '0;
						nxt_q.trial[q_ff.bitp] = q_ff.s2[4];
						if (q_ff.bitp != 4'h0) begin
							nxt_q.trial[q_ff.bitp - 4'h1] = 1'b1;
						end else begin
							nxt_q.push = 1'b1;
							nxt_q.hold = 1'b0;
						end
						nxt_q.bitp = q_ff.bitp - 4'h1;
					end else begin
						nxt_q.dec = q_ff.dec + 9'h1;
					end
				end
				// R18: internal clock timing
				// R3: shift on falling edge
				if (!ext && q_ff.cyc >= sasr_pkg::RISE0_C && q_ff.nbit < sasr_pkg::BIT_COUNT) begin
					nxt_q.ph = (q_ff.ph == sasr_pkg::PER_C - 9'h1) ? 9'h0 : q_ff.ph + 9'h1;
					if (q_ff.ph == 9'h0) begin
						nxt_q.iclk = 1'b1;
					end
					if (q_ff.ph == sasr_pkg::HIGH_C) begin
						nxt_q.iclk = 1'b0;
						nxt_q.sr = {q_ff.sr[10:0], 1'b0};
						nxt_q.nbit = q_ff.nbit + 4'h1;
					end
				end
				// R17: bounded conversion cycle
				// R19: busy after tail
				// R6: busy spans transfer
				if (q_ff.cyc == sasr_pkg::BUSY_C - 13'h1) begin
					nxt_q.st = sasr_pkg::SASR_COPY;
				end
			end
			sasr_pkg::SASR_COPY: begin
				nxt_q.cyc = q_ff.cyc + 13'h1;
				// R7: copy and busy rise in same cycle
				if (fifo_out_valid) begin
					if (load_ok) begin
						nxt_q.sr = fifo_out_data;
					end
					nxt_q.busy_n = 1'b1;
					nxt_q.st = sasr_pkg::SASR_IDLE;
				end
			end
			default: begin
				nxt_q.st = sasr_pkg::SASR_IDLE;
			end
		endcase
		// R4: MSB first output
		if (!ext) begin
			// R5: data moves after fall
			nxt_q.dout = (q_ff.st == sasr_pkg::SASR_CONVERT_STROBE_N && q_ff.nbit < sasr_pkg::BIT_COUNT) ? q_ff.sr[11] : 1'b0;
			nxt_q.ph = (nxt_q.st == sasr_pkg::SASR_CONVERT_STROBE_N) ? nxt_q.ph : 9'h0;
		end else begin
			nxt_q.iclk = 1'b0;
		end
		// R24: select gates outputs
		// R23: clock driven in internal mode
		nxt_q.data_oe = ~cs_n;
		nxt_q.busy_oe = ~cs_n;
		nxt_q.clk_oe = ~cs_n & ~ext;
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			q_ff <= '0;
			q_ff.st <= sasr_pkg::SASR_IDLE;
			q_ff.busy_n <= sasr_pkg::RST_BUSY_N;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign SERIAL_BIT_CLOCK_O = q_ff.iclk;
	assign SERIAL_BIT_CLOCK_OE_O = q_ff.clk_oe;
	assign DATA_O = q_ff.dout;
	assign DATA_OE_O = q_ff.data_oe;
	assign BUSY_N_O = q_ff.busy_n;
	assign BUSY_OE_O = q_ff.busy_oe;
	assign SAMPLE_HOLD_O = q_ff.hold;
	assign TRIAL_CODE_O = q_ff.trial;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_B_I);

	busy_fall_a: assert property ( // R1
		(q_ff.st == sasr_pkg::SASR_IDLE && convert_strobe_n_fall) |=> !BUSY_N_O && SAMPLE_HOLD_O
	) else $error("busy did not fall after convert edge");

	busy_len_a: assert property ( // R2
		!BUSY_N_O |-> q_ff.cyc < sasr_pkg::BUSY_MAX_C
	) else $error("busy held low too long");

	edge_ignore_a: assert property ( // R10
		(q_ff.st == sasr_pkg::SASR_CONVERT_STROBE_N && convert_strobe_n_fall && q_ff.cyc < sasr_pkg::BUSY_C - 13'h1) |=>
		(q_ff.cyc == $past(q_ff.cyc) + 13'h1)
	) else $error("convert edge restarted a running conversion");

	select_free_a: assert property ( // R11
		(q_ff.st == sasr_pkg::SASR_IDLE && convert_strobe_n_fall && cs_n) |=> q_ff.st == sasr_pkg::SASR_CONVERT_STROBE_N
	) else $error("conversion blocked by device select");

	first_rise_a: assert property ( // R18
		(q_ff.st == sasr_pkg::SASR_CONVERT_STROBE_N && !ext && $stable(ext) && q_ff.cyc == sasr_pkg::RISE0_C) |=>
		SERIAL_BIT_CLOCK_O
	) else $error("first internal clock rise misplaced");

	data_stable_a: assert property ( // R5
		($rose(SERIAL_BIT_CLOCK_O) && !ext) |=> $stable(DATA_O) [*8]
	) else $error("data changed near internal clock rise");

	busy_tail_a: assert property ( // R19
		($fell(SERIAL_BIT_CLOCK_O) && q_ff.nbit == sasr_pkg::BIT_COUNT && !ext) |->
		##[TAIL_LO:TAIL_HI] $rose(BUSY_N_O)
	) else $error("busy rise not 800 ns after last clock fall");

	ext_hold_a: assert property ( // R8
		(ext && !ext_rise && q_ff.st != sasr_pkg::SASR_COPY) |=> $stable(q_ff.sr)
	) else $error("shifter moved without host clock");

	discard_a: assert property ( // R25
		(q_ff.st == sasr_pkg::SASR_COPY && fifo_out_valid && !load_ok) |=> q_ff.sr == $past(q_ff.sr)
	) else $error("result loaded while host clock high");

	zero_tail_a: assert property ( // R26
		(ext_rise && q_ff.sr == 12'h000) |=> !DATA_O
	) else $error("data not low after twelve host clocks");

	select_oe_a: assert property ( // R24
		cs_n |=> !DATA_OE_O && !BUSY_OE_O && !SERIAL_BIT_CLOCK_OE_O
	) else $error("outputs enabled while deselected");

	data_fall_a: assert property ( // R5
		($fell(SERIAL_BIT_CLOCK_O) && !ext) |-> $stable(DATA_O)
	) else $error("data changed at internal clock fall");

	copy_load_a: assert property ( // R7
		(q_ff.st == sasr_pkg::SASR_COPY && fifo_out_valid && load_ok) |=>
		(q_ff.sr == $past(fifo_out_data)) && BUSY_N_O
	) else $error("result not copied as busy rose");

	track_early_a: assert property ( // R17
		$rose(BUSY_N_O) |-> !SAMPLE_HOLD_O
	) else $error("sample hold still holding at busy rise");

	ext_clk_off_a: assert property ( // R23
		ext |=> !SERIAL_BIT_CLOCK_O && !SERIAL_BIT_CLOCK_OE_O
	) else $error("bit clock driven in host clock mode");
endmodule : sasr_top

/* File: sasr_host_model.sv */
`timescale 1ns/1ps
module sasr_host_model (
	input wire logic data_i,
	input wire logic hold_i,
	output logic sclk_o,
	output logic [12:0] cap_o,
	output logic done_o
);
	logic burst_clk = 1'b0;
	logic [12:0] cap = 13'h0000;
	logic done = 1'b0;
	// quiet clock: The clock rests low between frames and is held high only when commanded.
	assign sclk_o = burst_clk | hold_i;
	assign cap_o = cap;
	assign done_o = done;
	always @(negedge sclk_o) begin
		cap <= {cap[11:0], data_i};
	end
	// late burst: Bursts of an 80 ns clock are issued only once the conversion is done.
	task automatic burst(input int n);
		#1.3;
		for (int k = 0; k < n; k++) begin
			#40 burst_clk = 1'b1;
			#40 burst_clk = 1'b0;
		end
		#100 done = ~done;
	endtask : burst
endmodule : sasr_host_model

/* File: sasr_top_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module sasr_top_test;
	logic clk = 1'b0;
	logic rst_b, cnv_n, sel_n, src, cmp, hold, host_clk, done;
	logic sbc, sbc_oe, data, data_oe, busy_n, busy_oe, sh;
	logic [11:0] trial, ana, wr, wf, a2;
	logic [12:0] cap, e;
	logic [12:0] exp_q[$];
	logic [11:0] vals[5];
	logic [31:0] seed = 32'hdab9981e;
	int error_cnt = 0;
	int check_count = 0;
	int nb = 0;
	always #2 clk = ~clk;
	sasr_top dut_u (.SYS_CLK_I(clk), .RST_B_I(rst_b), .CONVERT_STROBE_N_I(cnv_n), .DEVICE_SELECT_N_I(sel_n),
		.CLOCK_SOURCE_SELECT_I(src), .SERIAL_BIT_CLOCK_I(host_clk), .COMPARE_I(cmp), .SERIAL_BIT_CLOCK_O(sbc),
		.SERIAL_BIT_CLOCK_OE_O(sbc_oe), .DATA_O(data), .DATA_OE_O(data_oe), .BUSY_N_O(busy_n),
		.BUSY_OE_O(busy_oe), .SAMPLE_HOLD_O(sh), .TRIAL_CODE_O(trial));
	sasr_host_model host_u (.data_i(data), .hold_i(hold), .sclk_o(host_clk), .cap_o(cap), .done_o(done));
	// comparator model: The analog input is compared with the trial code.
	always @(posedge clk) cmp <= (trial <= ana);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
	endfunction : lfsr
	task automatic finish_test;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	always @(posedge sbc) begin
		wr = {wr[10:0], data};
		nb++;
	end
	always @(negedge sbc) wf = {wf[10:0], data};
	always @(negedge busy_n) nb = 0;
	always @(posedge busy_n) begin
		if (src === 1'b0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			`CHK({1'b0, wr}, e)
			`CHK(wf, wr)
			`CHK(nb, 12)
		end
	end
	always @(done) begin
		if (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			`CHK(cap, e)
		end
	end
	task automatic convert_strobe_n(input logic [11:0] a, input logic s, input logic extra, input logic hl);
		int n;
		int lo;
		int w;
		n = 0;
		lo = 0;
		seed = lfsr(seed);
		w = 10 + int'(seed[4:0]);
		ana <= a;
		sel_n <= s;
		// spacing: The strobe stays high long enough to keep the cycle above 25 us.
		repeat (2800) @(posedge clk);
		cnv_n <= 1'b0;
		while (n < 6000 && !(lo > 0 && busy_n === 1'b1)) begin
			@(posedge clk);
			n++;
			// short strobe: The strobe stays low for 40 ns or more.
			if (n == w) cnv_n <= 1'b1;
			// extra fall: A second fall comes well before 8 us.
			if (extra && n == 1000) cnv_n <= 1'b0;
			if (extra && n == 1010) cnv_n <= 1'b1;
			// held clock: The host keeps its clock high across the end of busy.
			if (hl && n == 1500) hold <= 1'b1;
			if (busy_n === 1'b0 && lo == 0) lo = n;
			if (n == 100) `CHK({sh, busy_oe, data_oe, sbc_oe}, {1'b1, ~s, ~s, ~s & ~src})
		end
		`CHK(lo > 0 && lo <= 31, 1'b1)
		`CHK(n - lo >= int'(sasr_pkg::BUSY_C) && n - lo <= int'(sasr_pkg::BUSY_C) + 8, 1'b1)
	endtask : convert_strobe_n
	initial begin
		rst_b = 1'b0;
		cnv_n = 1'b1;
		sel_n = 1'b0;
		src = 1'b0;
		hold = 1'b0;
		ana = 12'h000;
		vals = '{12'hfff, 12'h800, 12'h000, 12'h7ff, 12'h2c4};
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			if (i > 0) exp_q.push_back({1'b0, vals[i - 1] ^ 12'h800});
			convert_strobe_n(vals[i], 1'b0, i == 1, 1'b0);
		end
		src <= 1'b1;
		seed = lfsr(seed);
		a2 = seed[11:0];
		convert_strobe_n(a2, 1'b1, 1'b0, 1'b0);
		exp_q.push_back({a2 ^ 12'h800, 1'b0});
		convert_strobe_n(a2 ^ 12'h5a5, 1'b0, 1'b0, 1'b1);
		hold <= 1'b0;
		repeat (20) @(posedge clk);
		host_u.burst(12);
		repeat (20) @(posedge clk);
		finish_test();
	end
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		finish_test();
	end
endmodule : sasr_top_test
